// [bench/meifu_props.sv]
// Checker of the unit's register reads and request output
module meifu_props #(
  parameter bit HAS_ADC = 1'b1 // Converter variant
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire meifu_pkg::meifu_events_t ev,
  input wire meifu_pkg::meifu_ccp_mode_t ccp_mode,
  input wire logic ext_irq_pin,
  input wire logic [3:0] upper_port_b_pins,
  input wire logic irq_request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  logic rd_s; // Read setup cycle
  logic at_c; // Control register, any bank
  logic wr_c; // Write to control taken
  assign rd_s = psel && !penable && !pwrite && ce;
  assign at_c = !paddr[11] && paddr[8:0] == 9'h02c;
  assign wr_c = psel && penable && pwrite && ce && at_c;
  ////////////////////////////////////////////////////////////////////////////////
  // Unused bits of the byte registers never read high
  en1_bits_a: assert property (rd_s && paddr == 12'h230 |=> !prdata[7]
    && (HAS_ADC || !prdata[6])) else $error("en1 bits");
  en2_bits_a: assert property (rd_s && paddr == 12'h234 |=>
    (prdata[7:0] & 8'h2f) == 8'h00) else $error("en2 bits");
  fl2_bits_a: assert property (rd_s && paddr == 12'h034 |=>
    (prdata[7:0] & 8'h2f) == 8'h00) else $error("fl2 bits");
  upper_zero_a: assert property (rd_s |=> prdata[31:8] == 24'h0)
    else $error("upper bits");
  ctl_alias_a: assert property (psel && !penable && ce && at_c |=> !pslverr)
    else $error("alias refused");
  // Live levels copied at the setup edge
  ro_mirror_a: assert property (rd_s && paddr == 12'h030 |=>
    prdata[5:4] == $past({ev.serial_rx_full, ev.serial_tx_empty}))
    else $error("mirror bits");
  // Request follows the control byte two edges on
  gie_blocks_a: assert property (wr_c && !pwdata[7] |-> ##2 !irq_request)
    else $error("gie off");
  periph_irq_gate_blocks_a: assert property (wr_c && pwdata[7:3] == 5'h10 |-> ##2 !irq_request)
    else $error("periph_irq_gate off");
  core_src_a: assert property (wr_c && pwdata[7] && pwdata[5] && pwdata[2]
    |-> ##2 irq_request) else $error("core request");
  // A low enable holds off the bus answer
  ce_stall_a: assert property (!ce |-> !pready)
    else $error("stall");
endmodule

bind meifu_top meifu_props #(.HAS_ADC(HAS_ADC)) u_props (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .ev(ev), .ccp_mode(ccp_mode), .ext_irq_pin(ext_irq_pin),
  .upper_port_b_pins(upper_port_b_pins), .irq_request(irq_request));

// [bench/meifu_src.sv]
// Model of the timers, ports and serial units feeding the unit
module meifu_src (
  input wire logic pclk,
  output meifu_pkg::meifu_events_t ev,
  output meifu_pkg::meifu_ccp_mode_t ccp_mode,
  output logic ext_irq_pin,
  output logic [3:0] upper_port_b_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet sources at start
  initial begin
    ev = '0;
    ccp_mode = meifu_pkg::CCP_OFF;
    ext_irq_pin = 1'b0;
    upper_port_b_pins = 4'h0;
  end
  // One-cycle event pulse; a held level would re-set the flag
  task automatic pulse(input logic [12:0] m);
    ev <= ev | m;
    @(posedge pclk);
    ev <= ev & ~m;
    @(posedge pclk);
  endtask
  // Capture/compare mode level
  task automatic set_mode(input meifu_pkg::meifu_ccp_mode_t m);
    ccp_mode <= m;
    @(posedge pclk);
  endtask
  // Serial buffer levels
  task automatic levels(input logic rx, input logic tx);
    ev.serial_rx_full <= rx;
    ev.serial_tx_empty <= tx;
    @(posedge pclk);
  endtask
  // Pins, then time for the synchronisers and edge logic
  task automatic pins(input logic p, input logic [3:0] u);
    ext_irq_pin <= p;
    upper_port_b_pins <= u;
    repeat (6) @(posedge pclk);
  endtask
endmodule

// [bench/meifu_top_test.sv]
// Self-checking bench of the interrupt enable and flag unit
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module meifu_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_request, err;
  logic ce; // Clock enable, driven so the freeze is exercised
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd; // rd: last read word
  meifu_pkg::meifu_events_t ev;
  meifu_pkg::meifu_ccp_mode_t ccp_mode;
  logic ext_irq_pin;
  logic [3:0] upper_port_b_pins;
  int errors = 0;
  int checks = 0;
  // Source table: event, ccp mode, register, flag expected
  logic [12:0] ev_m [11] = '{13'h1000, 13'h0800, 13'h0400, 13'h0200, 13'h0100,
    13'h0040, 13'h0020, 13'h0060, 13'h0010, 13'h0008, 13'h0004};
  logic [1:0] ev_c [11] = '{1, 1, 1, 1, 1, 1, 3, 2, 1, 1, 1};
  logic [11:0] ev_a [11] = '{12'h02c, 12'h030, 12'h030, 12'h030, 12'h030, 12'h030,
    12'h030, 12'h030, 12'h034, 12'h034, 12'h034};
  logic [7:0] ev_x [11] = '{8'h04, 8'h01, 8'h02, 8'h40, 8'h08, 8'h04, 8'h04, 8'h00,
    8'h80, 8'h40, 8'h10};
  ////////////////////////////////////////////////////////////////////////////////
  meifu_top #(.HAS_ADC(1'b1)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .ev(ev), .ccp_mode(ccp_mode),
    .ext_irq_pin(ext_irq_pin), .upper_port_b_pins(upper_port_b_pins),
    .irq_request(irq_request));
  meifu_src src (.pclk(pclk), .ev(ev), .ccp_mode(ccp_mode), .ext_irq_pin(ext_irq_pin),
    .upper_port_b_pins(upper_port_b_pins));
  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // APB transfer; idle cycle after so psel is never set twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // The wait for the answer ends when pready goes high, or at the watchdog
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(nm, e, rd[7:0])
  endtask
  // Request settles two edges after a write
  task automatic irqchk(input logic e);
    repeat (2) @(posedge pclk);
    `CHK("irq", e, irq_request)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk("ctl", 12'h02c, 8'h00);
    rdchk("fl1", 12'h030, 8'h00);
    rdchk("en1", 12'h230, 8'h00);
    rdchk("en2", 12'h234, 8'h00);
    rdchk("edge", 12'h07c, 8'h40);
    wr(12'h230, 8'hff);
    rdchk("en1 rw", 12'h230, 8'h7f);
    wr(12'h234, 8'hff);
    rdchk("en2 rw", 12'h234, 8'hd0);
    wr(12'h230, 8'h00);
    wr(12'h234, 8'h00);
    apb(1'b0, 12'h040, 8'h00);
    `CHK("unmapped", 1'b1, err)
  endtask
  // Every pulsed event source with all gates shut, then software clear and sync port clear pulse
  task automatic t_flags;
    for (int i = 0; i < 11; i++) begin
      src.set_mode(meifu_pkg::meifu_ccp_mode_t'(ev_c[i]));
      src.pulse(ev_m[i]);
      rdchk("flag", ev_a[i], ev_x[i]);
      wr(ev_a[i], 8'h00);
      src.pulse(13'h0080);
      rdchk("cleared", ev_a[i], 8'h00);
    end
  endtask
  task automatic t_mirror;
    src.levels(1'b1, 1'b1);
    rdchk("mirror", 12'h030, 8'h30);
    wr(12'h030, 8'h00);
    rdchk("mirror ro", 12'h030, 8'h30);
    src.levels(1'b0, 1'b0);
    rdchk("mirror off", 12'h030, 8'h00);
  endtask
  task automatic t_gates;
    wr(12'h030, 8'h01);
    wr(12'h230, 8'h01);
    wr(12'h02c, 8'h80);
    irqchk(1'b0);
    wr(12'h02c, 8'hc0);
    irqchk(1'b1);
    wr(12'h02c, 8'h40);
    irqchk(1'b0);
    wr(12'h230, 8'h00);
    wr(12'h02c, 8'ha4);
    irqchk(1'b1);
    wr(12'h02c, 8'h94);
    irqchk(1'b0);
    wr(12'h02c, 8'h00);
    wr(12'h030, 8'h00);
  endtask
  // Enable low: no event lands and the bus stalls
  task automatic t_freeze;
    ce <= 1'b0;
    src.pulse(13'h1000);
    `CHK("stall", 1'b0, pready)
    ce <= 1'b1;
    rdchk("frozen", 12'h02c, 8'h00);
  endtask
  // Write through one bank, read back through the opposite one
  task automatic t_alias;
    for (int b = 0; b < 4; b++) begin
      wr(12'h02c + 12'(b) * 12'h200, 8'h20 >> b);
      rdchk("alias", 12'h62c - 12'(b) * 12'h200, 8'h20 >> b);
    end
    wr(12'h02c, 8'h00);
  endtask
  task automatic t_port_b_data_reg;
    src.pins(1'b0, 4'h5);
    rdchk("pch set", 12'h02c, 8'h01);
    wr(12'h02c, 8'h00);
    rdchk("pch held", 12'h02c, 8'h01);
    apb(1'b0, 12'h018, 8'h00);
    `CHK("port b", 4'h5, rd[7:4])
    wr(12'h02c, 8'h00);
    rdchk("pch clear", 12'h02c, 8'h00);
  endtask
  task automatic t_extpin;
    src.pins(1'b1, 4'h5);
    rdchk("rise", 12'h02c, 8'h02);
    wr(12'h02c, 8'h00);
    src.pins(1'b0, 4'h5);
    rdchk("fall off", 12'h02c, 8'h00);
    wr(12'h07c, 8'h00);
    src.pins(1'b1, 4'h5);
    rdchk("rise off", 12'h02c, 8'h00);
    src.pins(1'b0, 4'h5);
    rdchk("fall", 12'h02c, 8'h02);
    wr(12'h02c, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles of the run
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    wrap_up();
  end
  // Main sequence
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_flags();
    t_mirror();
    t_gates();
    t_alias();
    t_port_b_data_reg();
    t_extpin();
    t_freeze();
    wrap_up();
  end
endmodule

// [verilog/meifu_cfg.svh]
// Constants of the interrupt enable and flag unit: indices, bits, resets
`ifndef MEIFU_CFG_SVH
`define MEIFU_CFG_SVH
// Register indices; byte address is four times the index
`define MEIFU_IDX_INTCTL 7'h0b
`define MEIFU_IDX_FLAGS1 9'h00c
`define MEIFU_IDX_FLAGS2 9'h00d
`define MEIFU_IDX_EN1 9'h08c
`define MEIFU_IDX_EN2 9'h08d
`define MEIFU_IDX_PORT_B_DATA_REG 9'h006
`define MEIFU_IDX_EDGE 9'h01f
// Interrupt control bit positions
`define MEIFU_B_GIE 7
`define MEIFU_B_PERIPH_IRQ_GATE 6
`define MEIFU_B_T0_EN 5
`define MEIFU_B_EXT_EN 4
`define MEIFU_B_PCH_EN 3
`define MEIFU_B_T0_FL 2
`define MEIFU_B_EXT_FL 1
`define MEIFU_B_PCH_FL 0
// First peripheral register bit positions
`define MEIFU_B_ADC 6
`define MEIFU_B_RX 5
`define MEIFU_B_TX 4
`define MEIFU_B_SSP 3
`define MEIFU_B_CCP 2
`define MEIFU_B_T2 1
`define MEIFU_B_T1 0
// Second peripheral register bit positions
`define MEIFU_B_OSC 7
`define MEIFU_B_CMP 6
`define MEIFU_B_EE 4
// Edge select bit in the edge config register
`define MEIFU_B_EDGE 6
// Masks of implemented bits
`define MEIFU_EN1_MASK 8'h7f
`define MEIFU_EN1_NOADC 8'h3f
`define MEIFU_FL1_WMASK 8'h47
`define MEIFU_P2_MASK 8'hd0
// Reset values
`define MEIFU_RST_BYTE 8'h00
`define MEIFU_RST_EDGE 8'h40
`endif

// [verilog/meifu_pkg.sv]
// Types shared by the interrupt enable and flag unit
package meifu_pkg;
  // Register selected by an APB address
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_INTCTL = 3'h1,
    SEL_FLAGS1 = 3'h3,
    SEL_EN1 = 3'h2,
    SEL_FLAGS2 = 3'h6,
    SEL_EN2 = 3'h7,
    SEL_PORT_B_DATA_REG = 3'h5,
    SEL_EDGE = 3'h4
  } meifu_sel_t;

  // Mode of the capture/compare unit
  typedef enum logic [1:0] {
    CCP_OFF = 2'h0,
    CCP_CAPTURE = 2'h1,
    CCP_COMPARE = 2'h3,
    CCP_PWM = 2'h2
  } meifu_ccp_mode_t;

  // Event inputs from on-chip peripherals, same clock
  typedef struct packed {
    logic timer0_overflow;
    logic timer1_overflow;
    logic timer2_match;
    logic adc_done;
    logic sync_port_done;
    logic sync_port_clear;
    logic capture_event;
    logic compare_event;
    logic osc_fail;
    logic comparator_change;
    logic eeprom_write_done;
    logic serial_rx_full;
    logic serial_tx_empty;
  } meifu_events_t;
endpackage

// [verilog/meifu_top.sv]
// Interrupt enable and flag unit with an APB register slave
`include "meifu_cfg.svh"

module meifu_top #(
  parameter bit HAS_ADC = 1'b1 // Variant with a converter
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire meifu_pkg::meifu_events_t ev,
  input wire meifu_pkg::meifu_ccp_mode_t ccp_mode,
  input wire logic ext_irq_pin,
  input wire logic [3:0] upper_port_b_pins,
  output logic irq_request
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  // Shared by read mux and write strobes
  function automatic meifu_pkg::meifu_sel_t decode(input logic [11:0] a);
    logic [8:0] idx;
    idx = a[10:2];
    if (a[11] || (a[1:0] != 2'b00)) begin
      decode = meifu_pkg::SEL_NONE;
    end else if (idx[6:0] == `MEIFU_IDX_INTCTL) begin
      // Bank bits ignored so every bank sees it
      decode = meifu_pkg::SEL_INTCTL;
    end else if (idx == `MEIFU_IDX_FLAGS1) begin
      decode = meifu_pkg::SEL_FLAGS1;
    end else if (idx == `MEIFU_IDX_FLAGS2) begin
      decode = meifu_pkg::SEL_FLAGS2;
    end else if (idx == `MEIFU_IDX_EN1) begin
      decode = meifu_pkg::SEL_EN1;
    end else if (idx == `MEIFU_IDX_EN2) begin
      decode = meifu_pkg::SEL_EN2;
    end else if (idx == `MEIFU_IDX_PORT_B_DATA_REG) begin
      decode = meifu_pkg::SEL_PORT_B_DATA_REG;
    end else if (idx == `MEIFU_IDX_EDGE) begin
      decode = meifu_pkg::SEL_EDGE;
    end else begin
      decode = meifu_pkg::SEL_NONE;
    end
  endfunction

  meifu_pkg::meifu_sel_t sel; // Decoded register
  logic setup_ph; // APB setup cycle
  logic wr_fire; // Write completes this edge
  logic rd_fire; // Read completes this edge
  logic [7:0] wbyte; // Low byte of write data

  assign sel = decode(paddr);
  assign setup_ph = psel && !penable && ce;
  assign wr_fire = psel && penable && pwrite && ce;
  assign rd_fire = psel && penable && !pwrite && ce;
  assign wbyte = pwdata[7:0];

  // Zero wait state; a low enable stalls the transfer
  assign pready = ce;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [4:0] pin_raw; // Bit 4 is the external pin
  logic [4:0] sync1_ff; // First stage, read only by stage two
  logic [4:0] sync2_ff; // Safe to use

  assign pin_raw = {ext_irq_pin, upper_port_b_pins};

  // Two flops per pin against metastability
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else if (ce) begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // External pin edge detect

  logic ext_prev_ff; // Last synced pin level
  logic [7:0] edge_cfg_ff; // Edge config register
  logic ext_event; // Selected edge seen

  // Previous level for edge compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_ff <= 1'b0;
    end else if (ce) begin
      ext_prev_ff <= sync2_ff[4];
    end
  end

  // Rising edge when select is one, falling otherwise
  assign ext_event = edge_cfg_ff[`MEIFU_B_EDGE] ?
                     (sync2_ff[4] && !ext_prev_ff) :
                     (!sync2_ff[4] && ext_prev_ff);

  // Edge config register, only the select bit exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cfg_ff <= `MEIFU_RST_EDGE;
    end else if (wr_fire && sel == meifu_pkg::SEL_EDGE) begin
      edge_cfg_ff <= wbyte & (8'h01 << `MEIFU_B_EDGE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port change latch

  logic [3:0] port_b_data_reg_latch_ff; // Pin values at last port read
  logic [1:0] prime_ff; // Counts sync fill after reset
  logic pch_mismatch; // Pins differ from latch

  // Latch follows pins until the synchroniser is full, so a
  // pin held high at reset does not flag a false change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prime_ff <= 2'h0;
    end else if (ce && prime_ff != 2'h3) begin
      prime_ff <= prime_ff + 2'h1;
    end
  end

  // Reading the port register ends the mismatch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_data_reg_latch_ff <= 4'h0;
    end else if (ce && (prime_ff != 2'h3 ||
                 (rd_fire && sel == meifu_pkg::SEL_PORT_B_DATA_REG))) begin
      port_b_data_reg_latch_ff <= sync2_ff[3:0];
    end
  end

  // Any upper pin changed since the last read
  assign pch_mismatch = (prime_ff == 2'h3) && (sync2_ff[3:0] != port_b_data_reg_latch_ff);

  ////////////////////////////////////////////////////////////////////////
  // Interrupt control register

  logic [7:0] intctl_ff; // Gates, core enables, core flags
  logic [7:0] nxt_intctl; // Next value

  // Software write, then hardware sets on top
  always_comb begin
    nxt_intctl = intctl_ff;
    if (wr_fire && sel == meifu_pkg::SEL_INTCTL) begin
      nxt_intctl = wbyte;
    end
    // Sets regardless of any enable
    if (ev.timer0_overflow) begin
      nxt_intctl[`MEIFU_B_T0_FL] = 1'b1;
    end
    if (ext_event) begin
      nxt_intctl[`MEIFU_B_EXT_FL] = 1'b1;
    end
    // Re-set every cycle while mismatched, clear cannot hold
    if (pch_mismatch) begin
      nxt_intctl[`MEIFU_B_PCH_FL] = 1'b1;
    end
  end

  // Control register state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intctl_ff <= `MEIFU_RST_BYTE;
    end else if (ce) begin
      intctl_ff <= nxt_intctl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // First peripheral flags and enables

  logic [7:0] fl1_w_ff; // Writable flags: ADC, CCP, T2, T1
  logic [7:0] nxt_fl1_w; // Next value
  logic sync_port_ff; // Read-only sync port flag
  logic [7:0] fl1_view; // Register as software reads it
  logic [7:0] en1_ff; // First enable register
  logic [7:0] fl1_wmask; // Writable bits of this variant
  logic ccp_event; // Mode-qualified CCP event

  // No converter means the ADC bits read zero
  assign fl1_wmask = HAS_ADC ? `MEIFU_FL1_WMASK :
                     (`MEIFU_FL1_WMASK & ~(8'h01 << `MEIFU_B_ADC));

  // Capture or compare per mode, nothing in PWM
  always_comb begin
    case (ccp_mode)
      meifu_pkg::CCP_CAPTURE: ccp_event = ev.capture_event;
      meifu_pkg::CCP_COMPARE: ccp_event = ev.compare_event;
      default: ccp_event = 1'b0;
    endcase
  end

  // Writes store, hardware sets win over clears
  always_comb begin
    nxt_fl1_w = fl1_w_ff;
    if (wr_fire && sel == meifu_pkg::SEL_FLAGS1) begin
      nxt_fl1_w = wbyte;
    end
    if (ev.adc_done) begin
      nxt_fl1_w[`MEIFU_B_ADC] = 1'b1;
    end
    if (ccp_event) begin
      nxt_fl1_w[`MEIFU_B_CCP] = 1'b1;
    end
    if (ev.timer2_match) begin
      nxt_fl1_w[`MEIFU_B_T2] = 1'b1;
    end
    if (ev.timer1_overflow) begin
      nxt_fl1_w[`MEIFU_B_T1] = 1'b1;
    end
    nxt_fl1_w = nxt_fl1_w & fl1_wmask;
  end

  // Writable flag state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl1_w_ff <= `MEIFU_RST_BYTE;
    end else if (ce) begin
      fl1_w_ff <= nxt_fl1_w;
    end
  end

  // Software cannot write it; the port's own clear does,
  // and a done in the same cycle keeps it set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_port_ff <= 1'b0;
    end else if (ce) begin
      if (ev.sync_port_done) begin
        sync_port_ff <= 1'b1;
      end else if (ev.sync_port_clear) begin
        sync_port_ff <= 1'b0;
      end
    end
  end

  // Serial flags are live buffer status, not stored here
  always_comb begin
    fl1_view = fl1_w_ff;
    fl1_view[`MEIFU_B_RX] = ev.serial_rx_full;
    fl1_view[`MEIFU_B_TX] = ev.serial_tx_empty;
    fl1_view[`MEIFU_B_SSP] = sync_port_ff;
  end

  // Bit 7 never stored; ADC enable gone without converter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en1_ff <= `MEIFU_RST_BYTE;
    end else if (wr_fire && sel == meifu_pkg::SEL_EN1) begin
      en1_ff <= wbyte & (HAS_ADC ? `MEIFU_EN1_MASK : `MEIFU_EN1_NOADC);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Second peripheral flags and enables

  logic [7:0] fl2_ff; // Oscillator, comparator, EEPROM flags
  logic [7:0] nxt_fl2; // Next value
  logic [7:0] en2_ff; // Second enable register

  // Same write-then-set order as the other flags
  always_comb begin
    nxt_fl2 = fl2_ff;
    if (wr_fire && sel == meifu_pkg::SEL_FLAGS2) begin
      nxt_fl2 = wbyte & `MEIFU_P2_MASK;
    end
    if (ev.osc_fail) begin
      nxt_fl2[`MEIFU_B_OSC] = 1'b1;
    end
    if (ev.comparator_change) begin
      nxt_fl2[`MEIFU_B_CMP] = 1'b1;
    end
    if (ev.eeprom_write_done) begin
      nxt_fl2[`MEIFU_B_EE] = 1'b1;
    end
  end

  // Second flag state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl2_ff <= `MEIFU_RST_BYTE;
    end else if (ce) begin
      fl2_ff <= nxt_fl2;
    end
  end

  // Only bits 7, 6 and 4 are kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en2_ff <= `MEIFU_RST_BYTE;
    end else if (wr_fire && sel == meifu_pkg::SEL_EN2) begin
      en2_ff <= wbyte & `MEIFU_P2_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request to the core

  logic core_pend; // Enabled core source pending
  logic periph_pend; // Enabled peripheral source pending
  logic irq_ff; // Registered request
  logic nxt_irq; // Next request

  // Enables bits 5..3 pair with flags bits 2..0
  assign core_pend = |(intctl_ff[`MEIFU_B_T0_EN:`MEIFU_B_PCH_EN] &
                       intctl_ff[`MEIFU_B_T0_FL:`MEIFU_B_PCH_FL]);
  assign periph_pend = |(en1_ff & fl1_view) || |(en2_ff & fl2_ff);

  // Global gate over all, peripheral gate over peripherals
  assign nxt_irq = intctl_ff[`MEIFU_B_GIE] &&
                   (core_pend || (intctl_ff[`MEIFU_B_PERIPH_IRQ_GATE] && periph_pend));

  // One cycle behind the flags; a flag set before its enable
  // would request at once, so software clears first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_ff <= nxt_irq;
    end
  end

  assign irq_request = irq_ff;

  ////////////////////////////////////////////////////////////////////////
  // Read data and error

  logic [7:0] rd_byte; // Selected register value
  logic [31:0] prdata_ff; // Read data flop
  logic pslverr_ff; // Error flop

  // Read mux; unused bits read zero
  always_comb begin
    case (sel)
      meifu_pkg::SEL_INTCTL: rd_byte = intctl_ff;
      meifu_pkg::SEL_FLAGS1: rd_byte = fl1_view;
      meifu_pkg::SEL_FLAGS2: rd_byte = fl2_ff;
      meifu_pkg::SEL_EN1: rd_byte = en1_ff;
      meifu_pkg::SEL_EN2: rd_byte = en2_ff;
      meifu_pkg::SEL_PORT_B_DATA_REG: rd_byte = {sync2_ff[3:0], 4'h0};
      meifu_pkg::SEL_EDGE: rd_byte = edge_cfg_ff;
      default: rd_byte = 8'h00;
    endcase
  end

  // Captured in the setup cycle so data comes from a flop
  // while pready stays at zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (setup_ph) begin
      prdata_ff <= {24'h000000, rd_byte};
      pslverr_ff <= (sel == meifu_pkg::SEL_NONE);
    end
  end

  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

endmodule
